// >>> core/afe_aux_defs.svh
// Register offsets, field positions, reset values and timing counts of the auxiliary control bank.
// Assumes inclusion by bare name from the package file; the design modules use its macros without including it.
`ifndef AFE_AUX_DEFS_SVH
`define AFE_AUX_DEFS_SVH

`define OFS_DRIVE_NEG_SELECT   8'h0e
`define OFS_LEADOFF_POS_SENSE  8'h0f
`define OFS_LEADOFF_NEG_SENSE  8'h10
`define OFS_LEADOFF_CUR_DIR    8'h11
`define OFS_LEADOFF_POS_STATUS 8'h12
`define OFS_LEADOFF_NEG_STATUS 8'h13
`define OFS_GENERAL_IO_PORT    8'h14
`define OFS_PACER_SELECT       8'h15
`define OFS_BREATHING_CONTROL  8'h16
`define OFS_CONVERSION_MISC    8'h17

`define RST_ZERO8              8'h00
`define RST_GENERAL_IO         8'h0f
`define RST_BREATHING          8'h01
`define RST_IO_DIR4            4'hf

`define BREATH_MODE_NONE       2'h0
`define BREATH_MODE_EXT        2'h1
`define BREATH_MODE_ALT        2'h3

`define PACER_WMASK            8'h1f
`define BREATH_WMASK           8'h1f
`define CONV_WMASK             8'hee

`define CHAN_MASK_FOUR         8'h0f
`define CHAN_MASK_SIX          8'h3f
`define CHAN_MASK_EIGHT        8'hff

`define BREATH_CLK_HZ          2048000
`define BREATH_BASE_HZ         64000
`define CORE_CLK_HZ            20000000
`define BREATH_SUBSTEPS        16
`define BREATH_DIV_BITS        10

`endif

// >>> core/afe_aux_pkg.sv
// Types shared by the auxiliary control bank.
// Assumes afe_aux_defs.svh is on the include path.
`include "afe_aux_defs.svh"

package afe_aux_pkg;

  typedef enum logic [2:0]
  {
    bus_idle_type_st  = 3'b001,
    bus_setup_type_st = 3'b010,
    bus_access_type_st = 3'b100
  } bus_state_type;

  typedef enum logic [1:0]
  {
    variant_four_type  = 2'h0,
    variant_six_type   = 2'h1,
    variant_eight_type = 2'h2
  } variant_type;

endpackage : afe_aux_pkg

// >>> core/channel_route_mux.sv
// Routes one of four channel pacer signals to a pacer output.
// Assumes channel signals are synchronous to core_clk.
`timescale 1ns/10ps

module channel_route_mux
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Selection
  input  wire logic [1:0] route_select,
  input  wire logic       route_enable,
  input  wire logic [3:0] channel_in,
  // Result
  output logic            route_out
);

  logic route_ff;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      route_ff <= 1'b0;
    else
      route_ff <= route_enable & channel_in[route_select];
  end

  assign route_out = route_ff;

endmodule : channel_route_mux

// >>> core/breathing_phase_gen.sv
// Generates the two demodulation drive signals with programmable frequency and phase.
// Assumes core_clk at 20 MHz; the drive frequency base is derived from core_clk and the nominal 64 kHz.
`timescale 1ns/10ps

module breathing_phase_gen
  import afe_aux_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Controls
  input  wire logic       gen_enable,
  input  wire logic [2:0] frequency_code,
  input  wire logic [2:0] phase_code,
  input  wire logic       full_rate,
  // Drive outputs
  output logic            drive_ref,
  output logic            drive_shift
);

  localparam int unsigned STEP_CYCLES = `CORE_CLK_HZ / (`BREATH_BASE_HZ * `BREATH_SUBSTEPS);

  typedef struct packed
  {
    logic [`BREATH_DIV_BITS-1:0] tick_cnt;
    logic [11:0]                 phase_acc;
    logic                        ref_out;
    logic                        shift_out;
  } gen_state_type;

  gen_state_type cur_ff;
  gen_state_type nxt_cur;
  logic [3:0]    pos;
  logic [3:0]    offs;
  logic [3:0]    shifted;

  always_comb
  begin
    nxt_cur = cur_ff;
    pos     = cur_ff.phase_acc[frequency_code +: 4];
    // Programmed phase only at the two top rates and highest sample rate
    offs    = (frequency_code <= 3'h1 && full_rate) ? 4'(phase_code + 3'h1) : 4'h8;
    shifted = 4'(pos - offs);
    if (!gen_enable)
    begin
      nxt_cur = '0;
    end
    else if (cur_ff.tick_cnt == `BREATH_DIV_BITS'(STEP_CYCLES - 1))
    begin
      nxt_cur.tick_cnt  = '0;
      nxt_cur.phase_acc = 12'(cur_ff.phase_acc + 12'h1);
    end
    else
    begin
      nxt_cur.tick_cnt = `BREATH_DIV_BITS'(cur_ff.tick_cnt + 1'b1);
    end
    nxt_cur.ref_out   = gen_enable & ~pos[3];
    nxt_cur.shift_out = gen_enable & ~shifted[3];
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign drive_ref   = cur_ff.ref_out;
  assign drive_shift = cur_ff.shift_out;

endmodule : breathing_phase_gen

// >>> core/afe_auxiliary_control_regs.sv
// APB slave holding the auxiliary control and status registers of the front-end.
// Assumes APB signals synchronous to core_clk; analog status inputs already synchronous.
//
// Notes on behaviour
// - Set drive-negative-select bit adds that channel's negative input to leg drive.
// - Channels five, six absent on four-channel; seven, eight absent on four/six.
// - Positive sense bit enables lead-off detection on that channel's positive input.
// - Negative sense bit enables lead-off detection on that channel's negative input.
// - Current direction bit reverses lead-off excitation current on that channel.
// - Status registers are read-only; one means lead-off, zero lead-on by default.
// - Reading io data returns actual pin levels in any direction.
// - Writing io data sets driven level only on output pins.
// - Direction bit zero means output, one input; input after reset.
// - Breathing modes 01 and 11 take io pins two to four away.
// - Even pacer field routes channel two, four, six or eight to output two.
// - Odd pacer field routes channel one, three, five or seven to output one.
// - Pacer bit zero turns pacer buffer on; off after reset.
// - Breathing phase field offsets pin four from three in 22.5 degree steps.
// - Breathing phase acts only at the highest sample rate.
// - Breathing mode 00 none, 01 external by default; others not applicable.
// - Frequency field halves from 64 kHz down to 500 Hz per code.
// - Conversion bit three selects single-shot, else continuous after reset.
// - Conversion bit two closes central terminal to leg drive connection.
// - Conversion bit one enables lead-off comparators; disabled after reset.
`timescale 1ns/10ps

module afe_auxiliary_control_regs
  import afe_aux_pkg::*;
#(
  parameter variant_type VARIANT = variant_eight_type
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog side status
  input  wire logic [7:0]  leadoff_pos_flags,
  input  wire logic [7:0]  leadoff_neg_flags,
  input  wire logic [7:0]  pacer_channel_flags,
  input  wire logic        full_rate,
  // General io pins
  input  wire logic [3:0]  io_pin_in,
  output logic [3:0]       io_pin_out,
  output logic [3:0]       io_pin_oe,
  // Analog side controls
  output logic [7:0]       right_leg_drive_neg_en,
  output logic [7:0]       leadoff_pos_en,
  output logic [7:0]       leadoff_neg_en,
  output logic [7:0]       leadoff_flip_en,
  output logic             pacer_output_one,
  output logic             pacer_output_two,
  output logic             pacer_buffer_on,
  output logic             single_shot_mode,
  output logic             central_terminal_to_drive,
  output logic             leadoff_comparator_on
);

  typedef struct packed
  {
    bus_state_type bus_st;
    logic [31:0]   rdata;
    logic          ready;
    logic          slverr;
    logic [7:0]    drive_neg_select;
    logic [7:0]    leadoff_pos_sense;
    logic [7:0]    leadoff_neg_sense;
    logic [7:0]    leadoff_current_direction;
    logic [7:0]    leadoff_pos_status;
    logic [7:0]    leadoff_neg_status;
    logic [3:0]    io_pin_level;
    logic [3:0]    io_pin_direction;
    logic [1:0]    pacer_even_select;
    logic [1:0]    pacer_odd_select;
    logic          pacer_buffer_on;
    logic [2:0]    breathing_phase;
    logic [1:0]    breathing_mode;
    logic [2:0]    breathing_frequency;
    logic          single_shot;
    logic          central_terminal_to_drive;
    logic          leadoff_comparator_on;
    logic [3:0]    pin_out;
    logic [3:0]    pin_oe;
  } regs_state_type;

  regs_state_type cur_ff;
  regs_state_type nxt_cur;

  logic [7:0] chan_mask;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic       hit;
  logic       wr_now;
  logic       pins_taken;
  logic       drive_ref;
  logic       drive_shift;
  logic       pace_one;
  logic       pace_two;
  logic [3:0] odd_chans;
  logic [3:0] even_chans;
  wire logic [7:0] reg_idx = paddr[9:2];  // One register per word: byte address is four times the index

  ////////////////////////////////////////////////////////////////////////////
  // Variant channel mask

  always_comb
  begin
    if (VARIANT == variant_four_type)
      chan_mask = `CHAN_MASK_FOUR;
    else if (VARIANT == variant_six_type)
      chan_mask = `CHAN_MASK_SIX;
    else
      chan_mask = `CHAN_MASK_EIGHT;
  end

  assign pins_taken = (cur_ff.breathing_mode == `BREATH_MODE_EXT) ||
                      (cur_ff.breathing_mode == `BREATH_MODE_ALT);

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb
  begin
    hit   = 1'b1;
    rbyte = 8'h00;
    if (reg_idx == `OFS_DRIVE_NEG_SELECT)
      rbyte = cur_ff.drive_neg_select;
    else if (reg_idx == `OFS_LEADOFF_POS_SENSE)
      rbyte = cur_ff.leadoff_pos_sense;
    else if (reg_idx == `OFS_LEADOFF_NEG_SENSE)
      rbyte = cur_ff.leadoff_neg_sense;
    else if (reg_idx == `OFS_LEADOFF_CUR_DIR)
      rbyte = cur_ff.leadoff_current_direction;
    else if (reg_idx == `OFS_LEADOFF_POS_STATUS)
      rbyte = cur_ff.leadoff_pos_status;
    else if (reg_idx == `OFS_LEADOFF_NEG_STATUS)
      rbyte = cur_ff.leadoff_neg_status;
    else if (reg_idx == `OFS_GENERAL_IO_PORT)
      rbyte = {io_pin_in, cur_ff.io_pin_direction};
    else if (reg_idx == `OFS_PACER_SELECT)
      rbyte = {3'h0, cur_ff.pacer_even_select, cur_ff.pacer_odd_select, cur_ff.pacer_buffer_on};
    else if (reg_idx == `OFS_BREATHING_CONTROL)
      rbyte = {3'h0, cur_ff.breathing_phase, cur_ff.breathing_mode};
    else if (reg_idx == `OFS_CONVERSION_MISC)
      rbyte = {cur_ff.breathing_frequency, 1'b0, cur_ff.single_shot,
               cur_ff.central_terminal_to_drive, cur_ff.leadoff_comparator_on, 1'b0};
    else
      hit = 1'b0;
  end

  assign wbyte  = pwdata[7:0];
  assign wr_now = psel && penable && pwrite && pstrb[0] && hit && paddr[31:10] == 22'h0 && paddr[1:0] == 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    nxt_cur        = cur_ff;
    nxt_cur.ready  = 1'b0;
    nxt_cur.slverr = 1'b0;
    case (cur_ff.bus_st)
      bus_idle_type_st:
      begin
        if (psel && !penable)
          nxt_cur.bus_st = bus_setup_type_st;
      end
      bus_setup_type_st:
      begin
        // One wait state: answer registered at the end of the first access cycle
        if (psel && penable)
        begin
          nxt_cur.bus_st = bus_access_type_st;
          nxt_cur.ready  = 1'b1;
          nxt_cur.slverr = !hit || paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0 ||
                           (pwrite && (reg_idx == `OFS_LEADOFF_POS_STATUS ||
                                       reg_idx == `OFS_LEADOFF_NEG_STATUS));
          nxt_cur.rdata  = (nxt_cur.slverr || pwrite) ? 32'h0 : {24'h0, rbyte};
        end
        else if (!psel)
          nxt_cur.bus_st = bus_idle_type_st;
      end
      bus_access_type_st:
      begin
        nxt_cur.rdata  = 32'h0;
        nxt_cur.bus_st = (psel && !penable) ? bus_setup_type_st : bus_idle_type_st;
        if (wr_now && !cur_ff.slverr)
        begin
          if (reg_idx == `OFS_DRIVE_NEG_SELECT)
            nxt_cur.drive_neg_select = wbyte & chan_mask;
          else if (reg_idx == `OFS_LEADOFF_POS_SENSE)
            nxt_cur.leadoff_pos_sense = wbyte & chan_mask;
          else if (reg_idx == `OFS_LEADOFF_NEG_SENSE)
            nxt_cur.leadoff_neg_sense = wbyte & chan_mask;
          else if (reg_idx == `OFS_LEADOFF_CUR_DIR)
            nxt_cur.leadoff_current_direction = wbyte & chan_mask;
          else if (reg_idx == `OFS_GENERAL_IO_PORT)
          begin
            nxt_cur.io_pin_direction = wbyte[3:0];
            // Output pins take the new level; input pins keep the old one
            nxt_cur.io_pin_level = (wbyte[7:4] & ~cur_ff.io_pin_direction) |
                                   (cur_ff.io_pin_level & cur_ff.io_pin_direction);
          end
          else if (reg_idx == `OFS_PACER_SELECT)
          begin
            nxt_cur.pacer_even_select = wbyte[4:3];
            nxt_cur.pacer_odd_select  = wbyte[2:1];
            nxt_cur.pacer_buffer_on   = wbyte[0];
          end
          else if (reg_idx == `OFS_BREATHING_CONTROL)
          begin
            nxt_cur.breathing_phase = wbyte[4:2];
            nxt_cur.breathing_mode  = wbyte[1:0];
          end
          else if (reg_idx == `OFS_CONVERSION_MISC)
          begin
            nxt_cur.breathing_frequency       = wbyte[7:5];
            nxt_cur.single_shot               = wbyte[3];
            nxt_cur.central_terminal_to_drive = wbyte[2];
            nxt_cur.leadoff_comparator_on     = wbyte[1];
          end
        end
      end
      default:
      begin
        nxt_cur.bus_st = bus_idle_type_st;
      end
    endcase
    // Status snapshots follow the comparators, masked to channels present
    nxt_cur.leadoff_pos_status = leadoff_pos_flags & chan_mask;
    nxt_cur.leadoff_neg_status = leadoff_neg_flags & chan_mask;
    // Pins two to four belong to the breathing drive in modes 01 and 11
    nxt_cur.pin_oe  = ~cur_ff.io_pin_direction;
    nxt_cur.pin_out = cur_ff.io_pin_level & ~cur_ff.io_pin_direction;
    if (pins_taken)
    begin
      nxt_cur.pin_oe[3:1]  = 3'h7;
      nxt_cur.pin_out[1]   = 1'b0;
      nxt_cur.pin_out[2]   = drive_ref;
      nxt_cur.pin_out[3]   = drive_shift;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_ff                  <= '0;
      cur_ff.bus_st           <= bus_idle_type_st;
      cur_ff.io_pin_direction <= `RST_IO_DIR4;
      cur_ff.breathing_mode   <= 2'(`RST_BREATHING);
    end
    else
      cur_ff <= nxt_cur;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Breathing drive and pacer routing

  breathing_phase_gen u_breathing
  (
    .core_clk       (core_clk),
    .reset_n        (reset_n),
    .gen_enable     (pins_taken),
    .frequency_code (cur_ff.breathing_frequency),
    .phase_code     (cur_ff.breathing_phase),
    .full_rate      (full_rate),
    .drive_ref      (drive_ref),
    .drive_shift    (drive_shift)
  );

  assign odd_chans  = {pacer_channel_flags[6], pacer_channel_flags[4], pacer_channel_flags[2], pacer_channel_flags[0]};
  assign even_chans = {pacer_channel_flags[7], pacer_channel_flags[5], pacer_channel_flags[3], pacer_channel_flags[1]};

  channel_route_mux u_pace_odd
  (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .route_select (cur_ff.pacer_odd_select),
    .route_enable (cur_ff.pacer_buffer_on),
    .channel_in   (odd_chans),
    .route_out    (pace_one)
  );

  channel_route_mux u_pace_even
  (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .route_select (cur_ff.pacer_even_select),
    .route_enable (cur_ff.pacer_buffer_on),
    .channel_in   (even_chans),
    .route_out    (pace_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata                    = cur_ff.rdata;
  assign pready                    = cur_ff.ready;
  assign pslverr                   = cur_ff.slverr;
  assign io_pin_out                = cur_ff.pin_out;
  assign io_pin_oe                 = cur_ff.pin_oe;
  assign right_leg_drive_neg_en    = cur_ff.drive_neg_select;
  assign leadoff_pos_en            = cur_ff.leadoff_pos_sense;
  assign leadoff_neg_en            = cur_ff.leadoff_neg_sense;
  assign leadoff_flip_en           = cur_ff.leadoff_current_direction;
  assign pacer_output_one          = pace_one;
  assign pacer_output_two          = pace_two;
  assign pacer_buffer_on           = cur_ff.pacer_buffer_on;
  assign single_shot_mode          = cur_ff.single_shot;
  assign central_terminal_to_drive = cur_ff.central_terminal_to_drive;
  assign leadoff_comparator_on     = cur_ff.leadoff_comparator_on;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_status_follows_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 cur_ff.leadoff_pos_status == ($past(leadoff_pos_flags) & chan_mask))
    else $error("positive status does not follow flags");

  a_status_readonly_err: assert property (@(posedge core_clk) disable iff (!reset_n)
    psel && !penable && pwrite && reg_idx == `OFS_LEADOFF_POS_STATUS ##1 psel && penable |=> pslverr)
    else $error("status write not refused");

  a_io_input_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
    pready && psel && pwrite && reg_idx == `OFS_GENERAL_IO_PORT && !pslverr && pstrb[0]
    |=> ((cur_ff.io_pin_level ^ $past(cur_ff.io_pin_level)) & $past(cur_ff.io_pin_direction)) == 4'h0)
    else $error("input pin level changed by write");

  a_io_dir_oe: assert property (@(posedge core_clk) disable iff (!reset_n)
    !pins_taken && $stable(cur_ff.io_pin_direction) |=> io_pin_oe == ~$past(cur_ff.io_pin_direction))
    else $error("pin enable does not follow direction");

  a_pins_taken: assert property (@(posedge core_clk) disable iff (!reset_n)
    pins_taken |=> io_pin_oe[3:1] == 3'h7)
    else $error("breathing pins not taken over");

  a_pace_odd_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    cur_ff.pacer_buffer_on |=> pacer_output_one == $past(odd_chans[cur_ff.pacer_odd_select]))
    else $error("odd pacer route wrong");

  a_pace_even_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    cur_ff.pacer_buffer_on |=> pacer_output_two == $past(even_chans[cur_ff.pacer_even_select]))
    else $error("even pacer route wrong");

  a_pace_off_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    !cur_ff.pacer_buffer_on [*2] |-> !pacer_output_one && !pacer_output_two)
    else $error("pacer output active with buffer off");

  a_variant_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
    (right_leg_drive_neg_en & ~chan_mask) == 8'h00)
    else $error("absent channel bit set");

  a_ready_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    psel && !penable ##1 psel && penable |=> pready ##1 !pready)
    else $error("ready timing wrong");

endmodule : afe_auxiliary_control_regs

// >>> test/apb_host_model.sv
// Host controller model: an APB master that performs one transfer per call of xfer.
// Assumes a single caller; all signals change by non-blocking assignment after rising edges.
`timescale 1ns/10ps

module apb_host_model
(
  // Clock
  input  wire logic        core_clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end

  // Holds the request until pready is seen at a rising edge or 20 edges pass, then releases it
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    err = pslverr;
    hung = (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~data;
  endtask : xfer
endmodule : apb_host_model

// >>> test/afe_auxiliary_control_regs_tb.sv
// Self-checking bench of the auxiliary control bank, random stimulus from a fixed seed.
// Assumes register index times four is the byte address; pins resolved here from all drivers.
`timescale 1ns/10ps

module afe_auxiliary_control_regs_tb;
  import afe_aux_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, p1, p2, pbuf, ssm, ctd, lcmp, er, hung;
  logic        full_rate = 1'b0;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [31:0] seed = 32'd38469;
  logic [3:0]  pstrb, io_pin_out, io_pin_oe;
  logic [3:0]  ext_lvl = 4'h0;
  logic [7:0]  lo_pos = 8'h00, lo_neg = 8'h00, pace_fl = 8'h00, v;
  logic [7:0]  drv_en, pos_en, neg_en, flip_en;
  logic [31:0] rw_exp;
  int          err_total = 0;
  int          check_count = 0;
  int          diff_cnt = 0;
  localparam int DRIVE_PERIOD = `CORE_CLK_HZ / (`BREATH_BASE_HZ * `BREATH_SUBSTEPS) * `BREATH_SUBSTEPS;
  wire  [3:0]  pin_lvl = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext_lvl);

  always #25 core_clk = ~core_clk;

  apb_host_model host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  afe_auxiliary_control_regs #(.VARIANT(variant_eight_type)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .leadoff_pos_flags(lo_pos), .leadoff_neg_flags(lo_neg),
    .pacer_channel_flags(pace_fl), .full_rate(full_rate), .io_pin_in(pin_lvl), .io_pin_out(io_pin_out),
    .io_pin_oe(io_pin_oe), .right_leg_drive_neg_en(drv_en), .leadoff_pos_en(pos_en), .leadoff_neg_en(neg_en),
    .leadoff_flip_en(flip_en), .pacer_output_one(p1), .pacer_output_two(p2), .pacer_buffer_on(pbuf),
    .single_shot_mode(ssm), .central_terminal_to_drive(ctd), .leadoff_comparator_on(lcmp));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic pace_exp(logic [7:0] fl, logic [1:0] code, logic even, logic on);
    return on & fl[{code, even}];
  endfunction : pace_exp

  // Cycles per drive period in which pins three and four differ: twice the phase share of the period
  function automatic int diff_exp(logic [2:0] ph, int f, logic fr);
    return (fr && f < 2) ? (DRIVE_PERIOD << f) * (ph + 1) / 8 : (DRIVE_PERIOD << f);
  endfunction : diff_exp

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One transfer; the refusal flag is compared, read data is masked and compared
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic ex_err,
                     input logic [7:0] exp, input logic [7:0] msk);
    host.xfer(wr, {22'h0, idx, 2'b00}, {24'h0, d}, rdat, er, hung);
    if (hung)
    begin
      err_total++;
      end_sim();
    end
    chk(er, ex_err);
    if (!wr && !ex_err)
      chk(rdat & {24'h0, msk}, {24'h0, exp & msk});
  endtask : bus

  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask : settle

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    lo_pos <= rnd();
    lo_neg <= rnd();
    ext_lvl <= 4'(rnd());
    settle();
    bus(0, `OFS_GENERAL_IO_PORT, 0, 0, {4'h0, 4'hf}, 8'h0f);
    bus(0, `OFS_PACER_SELECT, 0, 0, 8'h00, 8'hff);
    bus(0, `OFS_BREATHING_CONTROL, 0, 0, 8'h01, 8'h03);
    bus(0, `OFS_CONVERSION_MISC, 0, 0, 8'h00, 8'hff);
    chk({pbuf, ssm, ctd, lcmp}, 4'h0);
    chk(io_pin_oe, 4'he);
    $display("test reset done");
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        v = (r == 0) ? 8'hff : rnd();
        rw_exp[8*i +: 8] = v;
        bus(1, 8'(`OFS_DRIVE_NEG_SELECT + i), v, 0, 0, 0);
        bus(0, 8'(`OFS_DRIVE_NEG_SELECT + i), 0, 0, v, 8'hff);
      end
      settle();
      chk({flip_en, neg_en, pos_en, drv_en}, rw_exp);
    end
    $display("test channel registers done");
    bus(1, `OFS_LEADOFF_POS_STATUS, 8'hff, 1, 0, 0);
    bus(1, `OFS_LEADOFF_NEG_STATUS, 8'hff, 1, 0, 0);
    bus(0, `OFS_LEADOFF_POS_STATUS, 0, 0, lo_pos, 8'hff);
    bus(0, `OFS_LEADOFF_NEG_STATUS, 0, 0, lo_neg, 8'hff);
    bus(0, 8'h18, 0, 1, 0, 0);
    $display("test status done");
    bus(1, `OFS_BREATHING_CONTROL, 8'h00, 0, 0, 0);
    v = rnd();
    bus(1, `OFS_GENERAL_IO_PORT, {4'h0, 4'h5}, 0, 0, 0);
    bus(1, `OFS_GENERAL_IO_PORT, {v[3:0], 4'h5}, 0, 0, 0);
    settle();
    chk(io_pin_oe, 4'ha);
    chk(io_pin_out & 4'ha, v[3:0] & 4'ha);
    bus(0, `OFS_GENERAL_IO_PORT, 0, 0, {(v[3:0] & 4'ha) | (ext_lvl & 4'h5), 4'h5}, 8'hff);
    for (int m = 1; m < 4; m += 2)
    begin
      bus(1, `OFS_BREATHING_CONTROL, 8'(m), 0, 0, 0);
      repeat (2) bus(1, `OFS_GENERAL_IO_PORT, {v[3:0], 4'h0}, 0, 0, 0);
      settle();
      chk({io_pin_oe, io_pin_out[0]}, {4'hf, v[0]});
    end
    $display("test general io done");
    for (int k = 0; k < 8; k++)
    begin
      pace_fl <= rnd();
      bus(1, `OFS_PACER_SELECT, {3'h0, 2'(k), 2'(k + 1), k[2]}, 0, 0, 0);
      settle();
      chk(pbuf, k[2]);
      chk(p1, pace_exp(pace_fl, 2'(k + 1), 1'b0, k[2]));
      chk(p2, pace_exp(pace_fl, 2'(k), 1'b1, k[2]));
    end
    $display("test pacer done");
    for (int k = 0; k < 3; k++)
    begin
      v = (k == 0) ? 8'h0e : rnd() & 8'h0e;
      bus(1, `OFS_CONVERSION_MISC, v, 0, 0, 0);
      bus(0, `OFS_CONVERSION_MISC, 0, 0, v, 8'hff);
      settle();
      chk({ssm, ctd, lcmp}, v[3:1]);
    end
    $display("test conversion done");
    for (int k = 0; k < 6; k++)
    begin
      v = rnd();
      full_rate <= k[0];
      bus(1, `OFS_CONVERSION_MISC, {3'(k >> 1), 5'h0}, 0, 0, 0);
      bus(1, `OFS_BREATHING_CONTROL, {3'h0, v[2:0], 2'h1}, 0, 0, 0);
      settle();
      diff_cnt = 0;
      repeat (DRIVE_PERIOD << (k >> 1))
      begin
        @(posedge core_clk);
        diff_cnt += int'(io_pin_out[2] !== io_pin_out[3]);
      end
      chk(diff_cnt, diff_exp(v[2:0], k >> 1, k[0]));
    end
    $display("test breathing drive done");
    end_sim();
  end
endmodule : afe_auxiliary_control_regs_tb
